// [core/atch_regs.vh]
// Constants of the alarm timer command handler.
`ifndef ATCH_REGS_VH
`define ATCH_REGS_VH
`define ATCH_CMD_ALARM_SET   8'hD0
`define ATCH_CMD_TIMER_READ  8'hD4
`define ATCH_CMD_STAMP_READ  8'hD8
`define ATCH_CMD_START_MEAS  8'hE4
`define ATCH_TIME_W          24
`define ATCH_DAY_W           16
`define ATCH_ZERO_TIME       24'h000000
`define ATCH_ZERO_DAY        16'h0000
`define ATCH_TICKS_PER_DAY   24'hFFFFFF
`define ATCH_IDX_W           3
`define ATCH_IDX_ZERO        3'h0
`define ATCH_IDX_ONE         3'h1
`define ATCH_ARG_LAST        3'h2
`define ATCH_TIMER_LAST      3'h3
`define ATCH_STAMP_LAST      3'h6
`endif

// [core/atch_byte_pick.v]
// Byte selector that serialises a response word least-significant byte first.
`timescale 1ns/1ns
`default_nettype none
`include "atch_regs.vh"
module atch_byte_pick (
   input  wire [55:0] word,
   input  wire [2:0]  idx,
   output reg  [7:0]  byte_out
);
   // Selects byte idx of the word; byte 0 is the lowest.
   always @* begin
      byte_out = word[idx*8 +: 8];
   end
endmodule
`default_nettype wire

// [core/atch_top.v]
// Alarm timer command handler: alarm set, timer read and time-stamp read.
// Behaviour
// - Alarm-set takes three argument bytes, coarse low, coarse high, fine; echo command.
// - Executing alarm-set clears running timer and day count.
// - After alarm-set, timer tasks stay off until start-measurement arrives.
// - Timer-read returns coarse low, coarse high, fine, then command echo.
// - Stamp-read first returns stamp one: coarse low, coarse high, fine.
// - Stamp-read then returns stamp two likewise, ending with command echo.
//
// Operating notes
// Command and argument bytes arrive as single-cycle strobes from the link receiver.
// Bytes that arrive while a reply is streaming are dropped, so the host must wait.
// Unknown command codes are ignored and produce no reply.
// The timer-read reply is a snapshot taken when the command byte arrives.
// Stamp events come from pins and pass two flip-flops before they are used.
// Stamps latch only while the timer runs; alarm-set leaves them untouched.
// The timer rolls over into the day count after its largest value.
// The alarm flag is a one-cycle pulse, one cycle after the timer meets the alarm.
`timescale 1ns/1ns
`default_nettype none
`include "atch_regs.vh"
module atch_top (
   input  wire        clk,
   input  wire        rst,
   input  wire        rx_valid,
   input  wire [7:0]  rx_byte,
   input  wire        tx_ready,
   input  wire        stamp_a_evt,
   input  wire        stamp_b_evt,
   output reg         tx_valid,
   output reg  [7:0]  tx_byte,
   output reg         timer_run,
   output reg  [23:0] alarm_time,
   output reg  [15:0] day_count,
   output reg         alarm_hit
);
   // ----------------------------------------
   // State codes
   // ----------------------------------------
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_ARGS = 2'h1;
   localparam [1:0] ST_SEND = 2'h2;

   reg [1:0]  state;
   reg [2:0]  idx;
   reg [2:0]  last_idx;
   reg [7:0]  cmd;
   reg [23:0] timer;
   reg [23:0] stamp_a;
   reg [23:0] stamp_b;
   reg [23:0] arg_buf;
   reg [55:0] resp;
   wire [7:0] pick;

   // ----------------------------------------
   // Command decoding
   // ----------------------------------------
   // Index of the last reply byte of a read command; zero for all others.
   function [2:0] reply_last;
      input [7:0] code;
      begin
         case (code)
            `ATCH_CMD_TIMER_READ: reply_last = `ATCH_TIMER_LAST;
            `ATCH_CMD_STAMP_READ: reply_last = `ATCH_STAMP_LAST;
            default:              reply_last = `ATCH_IDX_ZERO;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Event input synchronisers
   // ----------------------------------------
   // Bit 0 carries the first stamp event, bit 1 the second.
   wire [1:0] evt_pin = {stamp_b_evt, stamp_a_evt};
   wire [1:0] evt_sync;
   genvar     g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_evt_sync
         reg meta;
         reg sync;
         // Two flip-flops guard the logic against a metastable event pin.
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               meta <= 1'b0;
               sync <= 1'b0;
            end else begin
               meta <= evt_pin[g];
               sync <= meta;
            end
         end
         assign evt_sync[g] = sync;
      end
   endgenerate

   // Response byte picker.
   atch_byte_pick u_pick (
      .word     (resp),
      .idx      (idx),
      .byte_out (pick)
   );

   // ----------------------------------------
   // Command sequencer
   // ----------------------------------------
   // Receives commands and arguments and streams responses.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state      <= ST_IDLE;
         idx        <= `ATCH_IDX_ZERO;
         last_idx   <= `ATCH_IDX_ZERO;
         cmd        <= 8'h00;
         arg_buf    <= `ATCH_ZERO_TIME;
         resp       <= 56'h00000000000000;
         tx_valid   <= 1'b0;
         tx_byte    <= 8'h00;
         timer_run  <= 1'b0;
         alarm_time <= `ATCH_ZERO_TIME;
      end else begin
         case (state)
            // Waits for a command byte and decodes it.
            ST_IDLE: begin
               if (rx_valid) begin
                  cmd <= rx_byte;
                  idx <= `ATCH_IDX_ZERO;
                  if (rx_byte == `ATCH_CMD_ALARM_SET) begin
                     state <= ST_ARGS;
                  end else if (rx_byte == `ATCH_CMD_TIMER_READ) begin
                     resp     <= {24'h000000, rx_byte, timer};
                     last_idx <= reply_last(rx_byte);
                     state    <= ST_SEND;
                  end else if (rx_byte == `ATCH_CMD_STAMP_READ) begin
                     resp     <= {rx_byte, stamp_b, stamp_a};
                     last_idx <= reply_last(rx_byte);
                     state    <= ST_SEND;
                  end else if (rx_byte == `ATCH_CMD_START_MEAS) begin
                     timer_run <= 1'b1;
                  end
               end
            end
            // Gathers the three alarm argument bytes.
            ST_ARGS: begin
               if (rx_valid) begin
                  arg_buf[idx*8 +: 8] <= rx_byte;
                  // The third byte completes the command.
                  if (idx == `ATCH_ARG_LAST) begin
                     alarm_time <= {rx_byte, arg_buf[15:0]};
                     timer_run  <= 1'b0;
                     resp       <= {48'h000000000000, cmd};
                     last_idx   <= `ATCH_IDX_ZERO;
                     idx        <= `ATCH_IDX_ZERO;
                     state      <= ST_SEND;
                  end else begin
                     idx <= idx + `ATCH_IDX_ONE;
                  end
               end
            end
            // Presents one reply byte at a time and waits for the host.
            ST_SEND: begin
               if (!tx_valid) begin
                  tx_valid <= 1'b1;
                  tx_byte  <= pick;
               end else if (tx_ready) begin
                  tx_valid <= 1'b0;
                  if (idx == last_idx) begin
                     state <= ST_IDLE;
                  end else begin
                     idx <= idx + `ATCH_IDX_ONE;
                  end
               end
            end
            // Recovers from an illegal state code.
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Timer, day count and stamps
   // ----------------------------------------
   // Flags the cycle in which an alarm-set completes.
   wire set_done = (state == ST_ARGS) && rx_valid && (idx == `ATCH_ARG_LAST);

   // Advances the timer while enabled; alarm-set clears timer and days.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         timer     <= `ATCH_ZERO_TIME;
         day_count <= `ATCH_ZERO_DAY;
         alarm_hit <= 1'b0;
         stamp_a   <= `ATCH_ZERO_TIME;
         stamp_b   <= `ATCH_ZERO_TIME;
      end else begin
         if (set_done) begin
            timer     <= `ATCH_ZERO_TIME;
            day_count <= `ATCH_ZERO_DAY;
            alarm_hit <= 1'b0;
         end else if (timer_run) begin
            // Rolls the timer into the day count at its top value.
            if (timer == `ATCH_TICKS_PER_DAY) begin
               timer     <= `ATCH_ZERO_TIME;
               day_count <= day_count + 16'h0001;
            end else begin
               timer <= timer + 24'h000001;
            end
            // The alarm pulse compares the value before this tick.
            alarm_hit <= (timer == alarm_time);
         end else begin
            alarm_hit <= 1'b0;
         end
         // Latches event stamps while measuring.
         if (timer_run && evt_sync[0]) begin
            stamp_a <= timer;
         end
         // The second stamp latches in the same way.
         if (timer_run && evt_sync[1]) begin
            stamp_b <= timer;
         end
      end
   end
endmodule
`default_nettype wire

// [tb/atch_properties.sv]
// Port checker of the alarm timer command handler.
`timescale 1ns/1ns
`default_nettype none
module atch_properties (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        rx_valid,
   input wire logic        tx_ready,
   input wire logic        tx_valid,
   input wire logic        timer_run,
   input wire logic        alarm_hit,
   input wire logic [7:0]  rx_byte,
   input wire logic [7:0]  tx_byte,
   input wire logic [23:0] alarm_time,
   input wire logic [15:0] day_count
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_hold_byte: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
      else $error("reply byte lost");
   a_gap_after: assert property (tx_valid && tx_ready |=> !tx_valid)
      else $error("no gap");
   a_reply_start: assert property ($rose(tx_valid) |-> $past(rx_valid, 2) || $past(tx_valid, 2))
      else $error("late reply");
   a_run_start: assert property ($rose(timer_run) |-> $past(rx_byte == 8'hE4 && rx_valid)
      || $past(rx_byte == 8'hE4 && rx_valid, 2)) else $error("run without start");
   a_stop_on_set: assert property ($changed(alarm_time) |-> ##[0:1] !timer_run)
      else $error("run after set");
   a_day_clear: assert property ($changed(alarm_time) |-> ##[0:1] day_count == 16'h0000)
      else $error("day kept");
   a_day_hold: assert property (!timer_run |=> $stable(day_count) || day_count == 16'h0000)
      else $error("day moved");
   a_hit_running: assert property (alarm_hit |-> $past(timer_run))
      else $error("hit while off");
endmodule
bind atch_top atch_properties chk (.clk(clk), .rst(rst), .rx_valid(rx_valid),
   .tx_ready(tx_ready), .tx_valid(tx_valid), .timer_run(timer_run), .alarm_hit(alarm_hit),
   .rx_byte(rx_byte), .tx_byte(tx_byte), .alarm_time(alarm_time), .day_count(day_count));
`default_nettype wire

// [tb/atch_host.sv]
// Host model that takes reply bytes with random stalls.
`timescale 1ns/1ns
`default_nettype none
module atch_host (
   input  wire logic clk,
   output var logic  tx_ready
);
   // Readiness is random each cycle, so replies meet stalls and prompt takes alike.
   initial tx_ready = 1'b0;
   always @(posedge clk) tx_ready <= 1'($urandom % 2);
endmodule
`default_nettype wire

// [tb/atch_top_bench.sv]
// Self-checking bench of the alarm timer command handler.
`timescale 1ns/1ns
`default_nettype none
module atch_top_bench;
   logic        clk = 0, rst = 1, rx_valid = 0, sa = 0, sb = 0;
   logic        tx_ready, tx_valid, timer_run, alarm_hit;
   logic [7:0]  rx_byte = 8'h00, tx_byte, exq[$];
   logic [23:0] alarm_time, a;
   logic [15:0] day_count;
   int          mismatches = 0, n_compared = 0, i, k;
   initial forever #25 clk = ~clk;
   atch_top uut (.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .tx_ready(tx_ready), .stamp_a_evt(sa), .stamp_b_evt(sb), .tx_valid(tx_valid),
      .tx_byte(tx_byte), .timer_run(timer_run), .alarm_time(alarm_time),
      .day_count(day_count), .alarm_hit(alarm_hit));
   atch_host host (.clk(clk), .tx_ready(tx_ready));
   task chk(input string n, input logic [23:0] e, g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task test_done;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task put(input logic [7:0] b);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_byte <= b;
      @(posedge clk);
      rx_valid <= 1'b0;
   endtask
   task drain;
      for (k = 0; k < 400 && exq.size() > 0; k++) @(posedge clk);
      if (exq.size() > 0) begin
         mismatches++;
         test_done;
      end
      repeat (2) @(posedge clk);
   endtask
   // Every byte the host takes while exq still holds bytes is checked against the expected reply.
   always @(posedge clk) if (tx_valid && tx_ready && exq.size() > 0)
      chk("tx_byte", {16'h0000, exq.pop_front()}, {16'h0000, tx_byte});
   initial begin
      i = $urandom(32'hFBAFF76B);
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 4; i++) begin
         a = (i == 3) ? 24'h000020 : 24'($urandom);
         exq = '{8'hD0};
         put(8'hD0);
         put(a[7:0]);
         put(a[15:8]);
         put(a[23:16]);
         drain;
         chk("alarm_time", a, alarm_time);
         chk("day_count", 24'h0, {8'h00, day_count});
         chk("timer_run", 24'h0, {23'h0, timer_run});
         exq = '{8'h00, 8'h00, 8'h00, 8'hD4};
         put(8'hD4);
         drain;
         sa <= 1'b1;
         sb <= 1'b1;
         @(posedge clk);
         sa <= 1'b0;
         sb <= 1'b0;
         exq = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hD8};
         put(8'hD8);
         drain;
         put(8'hE4);
         @(negedge clk);
         for (k = 0; k < 200 && alarm_hit !== 1'b1 && i == 3; k++) @(negedge clk);
         if (i == 3 && alarm_hit !== 1'b1) begin
            mismatches++;
            test_done;
         end
         chk("running", 24'h1, {23'h0, timer_run});
         if (i == 3) chk("alarm_hit", 24'h1, {23'h0, alarm_hit});
         $display("test %0d done", i);
      end
      test_done;
   end
endmodule
`default_nettype wire
